// ---- link_pkg.sv ----
package link_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLK_KHZ       = 1000000000 / CLK_PERIOD_PS;
  // Common 1 ms timebase
  localparam int TICK_TIME_US  = 1000;
  localparam int TICK_CYC      = CLK_KHZ * TICK_TIME_US / 1000;
  // Serial clock: allowed range and the rate the host uses
  localparam int SCL_MIN_KHZ   = 10;
  localparam int SCL_MAX_KHZ   = 100;
  localparam int SCL_FREQ_KHZ  = 50;
  localparam int QTR_CYC       = CLK_KHZ / (SCL_FREQ_KHZ * 4);
  // Clock-low timeout and stretch budgets, in ms
  localparam int TIMEOUT_MIN_MS  = 25;
  localparam int TIMEOUT_MAX_MS  = 35;
  localparam int HOST_STRETCH_MS = 10;
  localparam int DEV_STRETCH_MS  = 25;
  // Restart deglitch and watchdog periods
  localparam int DEGLITCH_MS   = 10;
  localparam int MS_PER_S      = 1000;
  localparam int WD_01_S       = 44;
  localparam int WD_10_S       = 88;
  localparam int WD_11_S       = 175;
  localparam int WD_CNT_W      = 18;
  localparam logic [1:0] WD_OFF        = 2'h0;
  localparam logic [1:0] WD_SEL_01     = 2'h1;
  localparam logic [1:0] WD_SEL_10     = 2'h2;
  localparam logic [1:0] WD_PERIOD_RST = 2'h3;
  // Charge option register: command code and period field
  localparam logic [7:0] CHARGE_OPTION_CMD = 8'h12;
  localparam int         WD_FIELD_LSB      = 13;
  // Bus address of the device; value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT  = 7'h2a;
  localparam int         XFER_BITS         = 36;
endpackage

// ---- link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface link_if;
  logic scl;
  logic sda;
  logic scl_dev_o;
  logic scl_dev_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  // Open-drain wired-AND of both ends, pulled up when nobody drives
  assign scl = !((scl_dev_oe && !scl_dev_o) || (scl_host_oe && !scl_host_o));
  assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
  modport dev (
    input  scl, sda,
    output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe
  );
  modport host (
    input  scl, sda,
    output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe
  );
endinterface
`default_nettype wire

// ---- device_end.sv ----
// What this block does
// - Clock low beyond 25 ms within a transfer (after a start) means timeout
// - On timeout abandon, reset serial, release lines
// - Stretching stays within stretch budgets
// - Period 01 expires after about 44 s
// - Period 10 expires after about 88 s
// - Period resets to 11, about 175 s
// - Restart acts only after 10 ms deglitch
// - Host may rewrite period field anytime
`timescale 1ns/1ps
`default_nettype none
module device_end #(
  parameter int TICK_CYCLES = link_pkg::TICK_CYC,
  parameter int WD_01_MS    = link_pkg::WD_01_S * link_pkg::MS_PER_S,
  parameter int WD_10_MS    = link_pkg::WD_10_S * link_pkg::MS_PER_S,
  parameter int WD_11_MS    = link_pkg::WD_11_S * link_pkg::MS_PER_S
) (
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  link_if.dev             BUS,
  input  wire logic       SLV_SCL_HOLD,
  input  wire logic       SLV_SDA_LOW,
  output logic            SER_RESET,
  output logic            BUS_TIMEOUT,
  input  wire logic       PERIOD_WE,
  input  wire logic [1:0] PERIOD_IN,
  output logic [1:0]      WD_PERIOD,
  input  wire logic       WD_KICK,
  output logic            WD_EXPIRE
);
  import link_pkg::*;

  localparam int CW = WD_CNT_W;
  localparam logic [CW-1:0] TICK_LAST   = CW'(TICK_CYCLES - 1);
  localparam logic [5:0]    LOW_LIMIT   = 6'(TIMEOUT_MIN_MS + 1);
  localparam logic [5:0]    STR_LIMIT   = 6'(DEV_STRETCH_MS);
  localparam logic [5:0]    DGL_LIMIT   = 6'(DEGLITCH_MS + 1);

  // 1 ms timebase
  logic [CW-1:0] tick_cnt;
  logic [CW-1:0] next_tick_cnt;
  logic          tick;

  always_comb begin
    tick          = (tick_cnt == TICK_LAST);
    next_tick_cnt = tick ? '0 : tick_cnt + CW'(1);
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // Bus monitor, clock-low timeout and stretch budget
  logic       scl_q;
  logic       sda_q;
  logic       active;
  logic       abandon;
  logic [5:0] low_ms;
  logic [5:0] str_ms;
  logic       scl_oe;
  logic       sda_oe;
  logic       next_active;
  logic       next_abandon;
  logic [5:0] next_low_ms;
  logic [5:0] next_str_ms;
  logic       next_scl_oe;
  logic       next_sda_oe;
  logic       next_ser_reset;
  logic       start_cond;
  logic       stop_cond;
  logic       timeout;

  always_comb begin
    start_cond     = BUS.scl && scl_q && sda_q && !BUS.sda;
    stop_cond      = BUS.scl && scl_q && !sda_q && BUS.sda;
    next_active    = active;
    next_abandon   = abandon;
    next_low_ms    = low_ms;
    next_str_ms    = str_ms;
    next_ser_reset = 1'b0;
    timeout        = 1'b0;
    if (BUS.scl || !active) begin
      next_low_ms = '0;
    end else if (tick && low_ms != LOW_LIMIT) begin
      next_low_ms = low_ms + 6'd1;
    end
    if (active && !abandon && low_ms == LOW_LIMIT) begin
      timeout = 1'b1;
    end
    if (scl_oe && tick && str_ms != STR_LIMIT) begin
      next_str_ms = str_ms + 6'd1;
    end
    if (start_cond) begin
      next_active  = 1'b1;
      next_abandon = 1'b0;
      next_str_ms  = '0;
    end else if (stop_cond) begin
      next_active  = 1'b0;
      next_abandon = 1'b0;
    end else if (timeout) begin
      next_abandon   = 1'b1;
      next_ser_reset = 1'b1;
      next_active    = 1'b0;
    end
    // Hold the clock only while the transfer is alive and the budget lasts; the data line only needs no abandon or timeout
    // Stretch only a low phase the host began; never pull a high clock down
    next_scl_oe = SLV_SCL_HOLD && next_active && !next_abandon
                  && next_str_ms != STR_LIMIT && (scl_oe || !BUS.scl);
    next_sda_oe = SLV_SDA_LOW && !next_abandon && !timeout;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      active    <= 1'b0;
      abandon   <= 1'b0;
      low_ms    <= '0;
      str_ms    <= '0;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      SER_RESET <= 1'b0;
    end else begin
      scl_q     <= BUS.scl;
      sda_q     <= BUS.sda;
      active    <= next_active;
      abandon   <= next_abandon;
      low_ms    <= next_low_ms;
      str_ms    <= next_str_ms;
      scl_oe    <= next_scl_oe;
      sda_oe    <= next_sda_oe;
      SER_RESET <= next_ser_reset;
    end
  end

  assign BUS.scl_dev_o  = 1'b0;
  assign BUS.sda_dev_o  = 1'b0;
  assign BUS.scl_dev_oe = scl_oe;
  assign BUS.sda_dev_oe = sda_oe;
  assign BUS_TIMEOUT    = abandon;

  // Host watchdog
  logic [1:0]    period;
  logic [5:0]    kick_ms;
  logic          kick_done;
  logic [CW-1:0] wd_ms;
  logic          wd_run;
  logic          expire;
  logic [1:0]    next_period;
  logic [5:0]    next_kick_ms;
  logic          next_kick_done;
  logic [CW-1:0] next_wd_ms;
  logic          next_wd_run;
  logic          next_expire;
  logic [CW-1:0] wd_last;
  logic          restart;

  always_comb begin
    case (period)
      WD_SEL_01: wd_last = CW'(WD_01_MS - 1);
      WD_SEL_10: wd_last = CW'(WD_10_MS - 1);
      default:   wd_last = CW'(WD_11_MS - 1);
    endcase
    next_period = PERIOD_WE ? PERIOD_IN : period;
    next_kick_ms   = kick_ms;
    next_kick_done = kick_done;
    restart        = 1'b0;
    if (!WD_KICK) begin
      next_kick_ms   = '0;
      next_kick_done = 1'b0;
    end else if (!kick_done && tick) begin
      next_kick_ms = kick_ms + 6'd1;
      if (next_kick_ms == DGL_LIMIT) begin
        restart        = 1'b1;
        next_kick_done = 1'b1;
      end
    end
    next_wd_ms  = wd_ms;
    next_wd_run = wd_run;
    next_expire = 1'b0;
    if (restart) begin
      next_wd_ms  = '0;
      next_wd_run = 1'b1;
    end else if (period == WD_OFF || !wd_run) begin
      next_wd_ms = '0;
    end else if (tick) begin
      if (wd_ms >= wd_last) begin
        next_expire = 1'b1;
        next_wd_run = 1'b0;
        next_wd_ms  = '0;
      end else begin
        next_wd_ms = wd_ms + CW'(1);
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      period    <= WD_PERIOD_RST;
      kick_ms   <= '0;
      kick_done <= 1'b0;
      wd_ms     <= '0;
      wd_run    <= 1'b1;
      expire    <= 1'b0;
    end else begin
      period    <= next_period;
      kick_ms   <= next_kick_ms;
      kick_done <= next_kick_done;
      wd_ms     <= next_wd_ms;
      wd_run    <= next_wd_run;
      expire    <= next_expire;
    end
  end

  assign WD_PERIOD = period;
  assign WD_EXPIRE = expire;
endmodule
`default_nettype wire

// ---- host_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_end #(
  parameter int         TICK_CYCLES = link_pkg::TICK_CYC,
  parameter int         QTR_CYCLES  = link_pkg::QTR_CYC,
  parameter logic [6:0] DEV_ADDR    = link_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  link_if.host             BUS,
  input  wire logic        REQ,
  input  wire logic [15:0] OPT_WORD,
  input  wire logic [1:0]  PERIOD,
  output logic             BUSY,
  output logic             DONE,
  output logic             NACK,
  output logic             TIMEOUT
);
  import link_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_START = 4'b0010,
    S_BIT   = 4'b0100,
    S_STOP  = 4'b1000
  } state_t;

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);
  localparam logic [11:0] QTR_LAST  = 12'(QTR_CYCLES - 1);
  localparam logic [5:0]  LOW_LIMIT = 6'(TIMEOUT_MIN_MS + 1);
  localparam logic [5:0]  BIT_LAST  = 6'(XFER_BITS - 1);

  logic [17:0] tick_cnt;
  logic [11:0] qtr_cnt;
  logic        tick;
  logic        qtr;
  state_t      state;
  logic [1:0]  ph;
  logic [5:0]  bit_idx;
  logic [3:0]  slot;
  logic [35:0] shreg;
  logic        scl_oe;
  logic        sda_oe;
  logic [5:0]  low_ms;
  state_t      next_state;
  logic [1:0]  next_ph;
  logic [5:0]  next_bit_idx;
  logic [3:0]  next_slot;
  logic [35:0] next_shreg;
  logic        next_scl_oe;
  logic        next_sda_oe;
  logic [5:0]  next_low_ms;
  logic        next_done;
  logic        next_nack;
  logic        next_timeout;
  logic [15:0] word;

  always_comb begin
    tick = (tick_cnt == TICK_LAST);
    qtr  = (qtr_cnt == QTR_LAST);
    word = OPT_WORD;
    word[WD_FIELD_LSB +: 2] = PERIOD;
    next_state   = state;
    next_ph      = ph;
    next_bit_idx = bit_idx;
    next_slot    = slot;
    next_shreg   = shreg;
    next_scl_oe  = scl_oe;
    next_sda_oe  = sda_oe;
    next_done    = 1'b0;
    next_nack    = NACK;
    next_timeout = 1'b0;
    next_low_ms  = (state == S_IDLE || BUS.scl) ? 6'd0 : low_ms;
    if (tick && !BUS.scl && state != S_IDLE && low_ms != LOW_LIMIT) begin
      next_low_ms = low_ms + 6'd1;
    end
    case (state)
      S_IDLE: begin
        if (REQ) begin
          next_shreg   = {DEV_ADDR, 1'b0, 1'b1, CHARGE_OPTION_CMD, 1'b1,
                          word[7:0], 1'b1, word[15:8], 1'b1};
          next_sda_oe  = 1'b1;
          next_nack    = 1'b0;
          next_bit_idx = '0;
          next_slot    = '0;
          next_ph      = '0;
          next_state   = S_START;
        end
      end
      S_START: begin
        // Hold the start condition a full quarter before the first clock low
        if (qtr) begin
          if (ph == 2'd0) begin
            next_ph = 2'd1;
          end else begin
            next_scl_oe = 1'b1;
            next_ph     = 2'd0;
            next_state  = S_BIT;
          end
        end
      end
      S_BIT: begin
        if (qtr) begin
          case (ph)
            2'd0: begin
              next_sda_oe = !shreg[35];
              next_ph     = 2'd1;
            end
            2'd1: begin
              next_scl_oe = 1'b0;
              next_ph     = 2'd2;
            end
            2'd2: begin
              // Wait out device stretching before sampling
              if (BUS.scl) begin
                if (slot == 4'd8 && BUS.sda) begin
                  next_nack = 1'b1;
                end
                next_ph = 2'd3;
              end
            end
            default: begin
              next_scl_oe  = 1'b1;
              next_shreg   = {shreg[34:0], 1'b1};
              next_ph      = 2'd0;
              next_bit_idx = bit_idx + 6'd1;
              next_slot    = (slot == 4'd8) ? 4'd0 : slot + 4'd1;
              if (bit_idx == BIT_LAST) begin
                next_state = S_STOP;
              end
            end
          endcase
        end
      end
      S_STOP: begin
        if (qtr) begin
          case (ph)
            2'd0: begin
              next_sda_oe = 1'b1;
              next_ph     = 2'd1;
            end
            2'd1: begin
              next_scl_oe = 1'b0;
              next_ph     = 2'd2;
            end
            default: begin
              if (BUS.scl) begin
                next_sda_oe = 1'b0;
                next_done   = 1'b1;
                next_state  = S_IDLE;
              end
            end
          endcase
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (state != S_IDLE && low_ms == LOW_LIMIT) begin
      next_scl_oe  = 1'b0;
      next_sda_oe  = 1'b0;
      next_timeout = 1'b1;
      next_done    = 1'b0;
      next_low_ms  = '0;
      next_state   = S_IDLE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tick_cnt <= '0;
      qtr_cnt  <= '0;
      state    <= S_IDLE;
      ph       <= '0;
      bit_idx  <= '0;
      slot     <= '0;
      shreg    <= '1;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      low_ms   <= '0;
      DONE     <= 1'b0;
      NACK     <= 1'b0;
      TIMEOUT  <= 1'b0;
    end else begin
      tick_cnt <= tick ? 18'd0 : tick_cnt + 18'd1;
      qtr_cnt  <= qtr ? 12'd0 : qtr_cnt + 12'd1;
      state    <= next_state;
      ph       <= next_ph;
      bit_idx  <= next_bit_idx;
      slot     <= next_slot;
      shreg    <= next_shreg;
      scl_oe   <= next_scl_oe;
      sda_oe   <= next_sda_oe;
      low_ms   <= next_low_ms;
      DONE     <= next_done;
      NACK     <= next_nack;
      TIMEOUT  <= next_timeout;
    end
  end

  assign BUS.scl_host_o  = 1'b0;
  assign BUS.sda_host_o  = 1'b0;
  assign BUS.scl_host_oe = scl_oe;
  assign BUS.sda_host_oe = sda_oe;
  assign BUSY            = (state != S_IDLE);
endmodule
`default_nettype wire

// ---- link_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module link_props #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_dev_o,
  input wire logic scl_dev_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic scl_q, sda_q, in_xfer, next_xfer, start, stop;
  int   low_cnt, next_low, dev_cnt, next_dev;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop  = scl && scl_q && !sda_q && sda;
  always_comb begin
    next_low  = scl ? 0 : low_cnt + 1;
    next_dev  = start ? 0 : dev_cnt + int'(scl_dev_oe);
    next_xfer = start ? 1'b1 : (stop ? 1'b0 : in_xfer);
  end
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      in_xfer <= 1'b0;
      low_cnt <= 0;
      dev_cnt <= 0;
    end else begin
      scl_q   <= scl;
      sda_q   <= sda;
      in_xfer <= next_xfer;
      low_cnt <= next_low;
      dev_cnt <= next_dev;
    end
  end
  chk_pull_low_only:
    assert property (!scl_dev_o && !sda_dev_o && !scl_host_o && !sda_host_o)
    else $error("line driven high");
  chk_reset_lines_free:
    assert property (!$past(RST_N) |-> !(scl_dev_oe || sda_dev_oe || scl_host_oe || sda_host_oe))
    else $error("line held after reset");
  chk_low_bounded:
    assert property (low_cnt < 35 * TICK_CYCLES) else $error("clock low too long");
  chk_host_waits_high:
    assert property ($rose(scl_host_oe) |-> $past(scl) && $past(scl, 2))
    else $error("host pulled clock before it was high");
  chk_start_hold:
    assert property (start |-> scl [*2]) else $error("clock fell too soon after start");
  chk_stop_quiet:
    assert property (stop |-> !scl_host_oe [*3]) else $error("clock pulled right after stop");
  chk_dev_idle_free:
    assert property (!in_xfer && !$past(in_xfer) |-> !scl_dev_oe)
    else $error("device stretched outside a transfer");
  chk_dev_budget:
    assert property (dev_cnt <= 26 * TICK_CYCLES + 2) else $error("device stretch over budget");
  cover property (start);
  cover property (stop);
  cover property (in_xfer && scl_dev_oe);
  cover property (low_cnt == 4 * TICK_CYCLES);
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import link_pkg::*;
  localparam int T = 20;
  typedef struct {int kind; int lo; int hi;} exp_t;
  logic        MCLK = 1'b0, RST_N = 1'b0, req = 1'b0, req2 = 1'b0;
  logic        we = 1'b0, kick = 1'b0, hold = 1'b0, slow = 1'b0, hold2 = 1'b0, low2 = 1'b0;
  logic [15:0] opt = 16'h0;
  logic [1:0]  per = 2'h0, pin = 2'h0, wdp, wdp2;
  logic        ser_rst, bto, ser_rst2, bto2, wd_exp, busy, done, nack, busy2, tmo, tmo2;
  logic        wd_exp2, done2, nack2;
  logic [31:0] rs = 32'h75bcfb63;
  logic [1:0]  pv[3] = '{WD_SEL_01, WD_SEL_10, WD_PERIOD_RST};
  int          wd[3] = '{50, 100, 200};
  int          fails = 0, checks = 0, cyc = 0;
  exp_t        q[$];
  exp_t        e;
  link_if bus1();
  link_if bus2();
  link_if bus3();
  device_end #(.TICK_CYCLES(T), .WD_01_MS(50), .WD_10_MS(100), .WD_11_MS(200)) device_end_i (
    .MCLK(MCLK), .RST_N(RST_N), .BUS(bus1), .SLV_SCL_HOLD(hold), .SLV_SDA_LOW(slow),
    .SER_RESET(ser_rst), .BUS_TIMEOUT(bto), .PERIOD_WE(we), .PERIOD_IN(pin),
    .WD_PERIOD(wdp), .WD_KICK(kick), .WD_EXPIRE(wd_exp));
  host_end #(.TICK_CYCLES(T), .QTR_CYCLES(4)) host_end_i (
    .MCLK(MCLK), .RST_N(RST_N), .BUS(bus1), .REQ(req), .OPT_WORD(opt), .PERIOD(per),
    .BUSY(busy), .DONE(done), .NACK(nack), .TIMEOUT(tmo));
  device_end #(.TICK_CYCLES(T), .WD_01_MS(50), .WD_10_MS(100), .WD_11_MS(200)) device_end_i2 (
    .MCLK(MCLK), .RST_N(RST_N), .BUS(bus2), .SLV_SCL_HOLD(hold2), .SLV_SDA_LOW(low2),
    .SER_RESET(ser_rst2), .BUS_TIMEOUT(bto2), .PERIOD_WE(we), .PERIOD_IN(pin),
    .WD_PERIOD(wdp2), .WD_KICK(kick), .WD_EXPIRE(wd_exp2));
  host_end #(.TICK_CYCLES(T), .QTR_CYCLES(4)) host_end_i2 (
    .MCLK(MCLK), .RST_N(RST_N), .BUS(bus3), .REQ(req2), .OPT_WORD(opt), .PERIOD(per),
    .BUSY(busy2), .DONE(done2), .NACK(nack2), .TIMEOUT(tmo2));
  link_props #(.TICK_CYCLES(T)) link_props_i (
    .MCLK(MCLK), .RST_N(RST_N), .scl(bus1.scl), .sda(bus1.sda),
    .scl_dev_o(bus1.scl_dev_o), .scl_dev_oe(bus1.scl_dev_oe),
    .sda_dev_o(bus1.sda_dev_o), .sda_dev_oe(bus1.sda_dev_oe),
    .scl_host_o(bus1.scl_host_o), .scl_host_oe(bus1.scl_host_oe),
    .sda_host_o(bus1.sda_host_o), .sda_host_oe(bus1.sda_host_oe));
  initial begin
    forever #2.5 MCLK = ~MCLK;
  end
  task err(string m);
    fails++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task chk(logic c, string m);
    checks++;
    if (c !== 1'b1) err(m);
  endtask
  task conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task tk(int n);
    repeat (n) @(negedge MCLK);
  endtask
  task note(int k, int lo, int hi);
    q.push_back('{k, cyc + lo, cyc + hi});
  endtask
  task drain();
    int n;
    n = 0;
    while (q.size() != 0 && n < 6000) begin
      tk(1);
      n++;
    end
    if (q.size() != 0) begin
      err("wait bound used up");
      conclude();
    end
  endtask
  task hwrite(int lo, int hi);
    logic [31:0] r;
    r = xs();
    opt = r[15:0];
    per = r[17:16];
    req = 1'b1;
    note(1, lo, hi);
    tk(1);
    req = 1'b0;
  endtask
  // Result codes: 1 write done, 2 write timeout, 3 expiry, 4 fault host timeout, 5 fault reset,
  // 6 never expected: expiry mismatch, done from the host facing the faulty device, reset on the clean bus
  function int seen();
    return done === 1'b1 ? 1 : tmo === 1'b1 ? 2
      : (wd_exp === 1'b1 || wd_exp2 === 1'b1) ? (wd_exp === wd_exp2 ? 3 : 6)
      : tmo2 === 1'b1 ? 4 : ser_rst2 === 1'b1 ? 5
      : (done2 === 1'b1 || ser_rst === 1'b1) ? 6 : 0;
  endfunction
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (seen() != 0) begin
      checks++;
      if (q.size() == 0) err("unexpected result");
      else begin
        e = q.pop_front();
        if (seen() != e.kind || cyc < e.lo || cyc > e.hi) err("wrong result or time");
      end
    end
  end
  initial begin
    {bus2.scl_host_o, bus2.sda_host_o, bus2.scl_host_oe, bus2.sda_host_oe} = 4'h0;
    {bus3.scl_dev_o, bus3.sda_dev_o, bus3.scl_dev_oe, bus3.sda_dev_oe} = 4'h0;
    tk(3);
    RST_N = 1'b1;
    chk(wdp === WD_PERIOD_RST && wdp2 === WD_PERIOD_RST, "period after reset");
    foreach (pv[i]) begin
      pin = pv[i];
      we = 1'b1;
      tk(1);
      we = 1'b0;
      tk(1);
      chk(wdp === pv[i] && wdp2 === pv[i], "period field");
      kick = 1'b1;
      note(3, (9 + wd[i]) * T, (12 + wd[i]) * T + 5);
      tk(300);
      kick = 1'b0;
      drain();
      $display("end of test expiry %0d", i);
    end
    // Short restart is filtered, and expiry does not rearm on its own
    kick = 1'b1;
    tk(100);
    kick = 1'b0;
    tk(4600);
    $display("end of test short restart");
    slow = 1'b1;
    tk(2);
    chk(bus1.sda === 1'b0, "data line not driven");
    slow = 1'b0;
    tk(2);
    chk(bus1.sda === 1'b1, "data line not released");
    hwrite(500, 900);
    drain();
    chk(nack === 1'b1 && busy === 1'b0, "ack slots not read or still busy");
    hold = 1'b1;
    tk(10);
    hwrite(650, 1400);
    tk(200);
    hold = 1'b0;
    drain();
    chk(bto === 1'b0, "stretch caused abandon");
    $display("end of test writes and stretch");
    // Faulty host keeps the clock low
    hold2 = 1'b1;
    low2 = 1'b1;
    bus2.sda_host_oe = 1'b1;
    note(5, 490, 545);
    tk(4);
    bus2.scl_host_oe = 1'b1;
    drain();
    tk(2);
    chk(bto2 === 1'b1 && bus2.scl_dev_oe === 1'b0 && bus2.sda_dev_oe === 1'b0, "no release");
    hold2 = 1'b0;
    low2 = 1'b0;
    bus2.scl_host_oe = 1'b0;
    tk(4);
    bus2.sda_host_oe = 1'b0;
    tk(3);
    chk(bto2 === 1'b0, "abandon kept after stop");
    $display("end of test device timeout");
    // Faulty device keeps the clock low
    req2 = 1'b1;
    note(4, 495, 580);
    tk(1);
    req2 = 1'b0;
    tk(2);
    bus3.scl_dev_oe = 1'b1;
    drain();
    tk(2);
    chk(bus3.scl_host_oe === 1'b0 && bus3.sda_host_oe === 1'b0 && busy2 === 1'b0, "host held");
    chk(done2 === 1'b0 && nack2 === 1'b0, "aborted write reported");
    bus3.scl_dev_oe = 1'b0;
    $display("end of test host timeout");
    conclude();
  end
endmodule
`default_nettype wire
